// [src/tpd_port_data.sv]
// Data registers for two general-purpose pin ports (10-pin and 16-pin).
// Assumes direction and function-select bits come from configuration
// logic on mclk, and pin levels arrive asynchronously from the board.
//
// Summary of operation
// R1: First port: ten pins, 16-bit register, bits 9..0 map to same pins.
// R2: Second port: sixteen pins, 16-bit register, bits 15..0 map to pins.
// R3: Direction 1 and general output: pin driven with written register bit.
// R4: General output read returns stored register bit, not pin level.
// R5: General input read returns current pin level, not stored bit.
// R6: General input write stores the bit, pin stays undriven.
// R7: Direction 0, other function: read pin level, write stored only.
// R8: Direction 1, other function: read stored bit, write stored only.
// R9: First port bits 15..10 read zero; software writes zero there.
// R10: Direction and function select are inputs; data clears on reset.
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "tpd_defs.svh"
module tpd_port_data #(
  parameter int FIRST_PINS  = `TPD_FIRST_PINS,
  parameter int SECOND_PINS = `TPD_SECOND_PINS,
  parameter int ADDR_W      = `TPD_ADDR_W
) (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst,

  // Register port
  input  wire logic [ADDR_W-1:0]      reg_addr,
  input  wire logic [`TPD_REG_W-1:0]  reg_wr_data,
  input  wire logic                   reg_wr_en,
  input  wire logic                   reg_rd_en,
  output logic      [`TPD_REG_W-1:0]  reg_rd_data,

  // Configuration for the first port
  input  wire logic [FIRST_PINS-1:0]  first_port_direction_bits,
  input  wire logic [FIRST_PINS-1:0]  first_port_general_sel,

  // Configuration for the second port
  input  wire logic [SECOND_PINS-1:0] second_port_direction_bits,
  input  wire logic [SECOND_PINS-1:0] second_port_general_sel,

  // First port pins
  input  wire logic [FIRST_PINS-1:0]  first_port_pin_in,
  output logic      [FIRST_PINS-1:0]  first_port_pin_out,
  output logic      [FIRST_PINS-1:0]  first_port_pin_oe,

  // Second port pins
  input  wire logic [SECOND_PINS-1:0] second_port_pin_in,
  output logic      [SECOND_PINS-1:0] second_port_pin_out,
  output logic      [SECOND_PINS-1:0] second_port_pin_oe
);

  // Address decode, shared by the write and read paths
  function automatic tpd_pkg::tpd_reg_sel_t decode_addr(
    input logic [ADDR_W-1:0] addr
  );
    tpd_pkg::tpd_reg_sel_t sel;
    sel = tpd_pkg::TPD_SEL_NONE;
    case (addr)
      ADDR_W'(`TPD_OFS_FIRST_DATA):   sel = tpd_pkg::TPD_SEL_FIRST_DATA;
      ADDR_W'(`TPD_OFS_SECOND_DATA):  sel = tpd_pkg::TPD_SEL_SECOND_DATA;
      ADDR_W'(`TPD_OFS_FIRST_LEVEL):  sel = tpd_pkg::TPD_SEL_FIRST_LEVEL;
      ADDR_W'(`TPD_OFS_SECOND_LEVEL): sel = tpd_pkg::TPD_SEL_SECOND_LEVEL;
      ADDR_W'(`TPD_OFS_FIRST_DRIVE):  sel = tpd_pkg::TPD_SEL_FIRST_DRIVE;
      ADDR_W'(`TPD_OFS_SECOND_DRIVE): sel = tpd_pkg::TPD_SEL_SECOND_DRIVE;
      default:                        sel = tpd_pkg::TPD_SEL_NONE;
    endcase
    return sel;
  endfunction : decode_addr

  // A pin is driven only as a general-purpose output
  function automatic logic drives_pin(
    input logic dir_bit,
    input logic general_bit
  );
    return dir_bit & general_bit;
  endfunction : drives_pin

  // Decoded selects
  tpd_pkg::tpd_reg_sel_t         wr_sel;
  tpd_pkg::tpd_reg_sel_t         rd_sel;

  // Stored data bits
  logic [FIRST_PINS-1:0]         first_data_r;
  logic [SECOND_PINS-1:0]        second_data_r;

  // Synchronised pin levels
  logic [FIRST_PINS-1:0]         first_level;
  logic [SECOND_PINS-1:0]        second_level;

  // Output enables
  logic [FIRST_PINS-1:0]         first_oe_r;
  logic [SECOND_PINS-1:0]        second_oe_r;
  logic [FIRST_PINS-1:0]         first_oe_nxt;
  logic [SECOND_PINS-1:0]        second_oe_nxt;

  // Per-bit read values of the data registers
  logic [FIRST_PINS-1:0]         first_view;
  logic [SECOND_PINS-1:0]        second_view;

  // Read word assembly
  tpd_pkg::tpd_word_t            rd_word;
  tpd_pkg::tpd_word_t            rd_data_r;

  assign wr_sel = reg_wr_en ? decode_addr(reg_addr) : tpd_pkg::TPD_SEL_NONE;
  assign rd_sel = reg_rd_en ? decode_addr(reg_addr) : tpd_pkg::TPD_SEL_NONE;

  // Pin inputs cross into mclk before any read path sees them
  tpd_sync2 #(
    .W        (FIRST_PINS)
  ) u_first_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (first_port_pin_in),
    .sync_out (first_level)
  );

  tpd_sync2 #(
    .W        (SECOND_PINS)
  ) u_second_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in (second_port_pin_in),
    .sync_out (second_level)
  );

  // First port data: writes always stored; upper bits dropped
  always_ff @(posedge mclk) begin
    if (rst) begin
      first_data_r <= FIRST_PINS'(`TPD_DATA_RST); // R10
    end else if (wr_sel == tpd_pkg::TPD_SEL_FIRST_DATA) begin
      first_data_r <= reg_wr_data[FIRST_PINS-1:0]; // R1 R6 R7 R8 R9
    end
  end

  // Second port data: writes always stored
  always_ff @(posedge mclk) begin
    if (rst) begin
      second_data_r <= SECOND_PINS'(`TPD_DATA_RST); // R10
    end else if (wr_sel == tpd_pkg::TPD_SEL_SECOND_DATA) begin
      second_data_r <= reg_wr_data[SECOND_PINS-1:0]; // R2 R6 R7 R8
    end
  end

  // Enables follow the configuration, one cycle later
  always_comb begin
    first_oe_nxt  = '0;
    second_oe_nxt = '0;
    for (int i = 0; i < FIRST_PINS; i++) begin
      first_oe_nxt[i] = drives_pin(first_port_direction_bits[i],
                                   first_port_general_sel[i]); // R3 R6
    end
    for (int j = 0; j < SECOND_PINS; j++) begin
      second_oe_nxt[j] = drives_pin(second_port_direction_bits[j],
                                    second_port_general_sel[j]); // R3 R6
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      first_oe_r  <= '0;
      second_oe_r <= '0;
    end else begin
      first_oe_r  <= first_oe_nxt; // R3 R7 R8
      second_oe_r <= second_oe_nxt; // R3 R7 R8
    end
  end

  // Pin value is the stored bit; it reaches the wire only when enabled
  assign first_port_pin_out  = first_data_r; // R3
  assign second_port_pin_out = second_data_r; // R3
  assign first_port_pin_oe   = first_oe_r;
  assign second_port_pin_oe  = second_oe_r;

  // Read view of the first port, bit by bit
  genvar gf;
  generate
    for (gf = 0; gf < FIRST_PINS; gf++) begin : g_first_view
      // Direction 1 reads the store, direction 0 reads the pin
      assign first_view[gf] = first_port_direction_bits[gf] ?
                              first_data_r[gf] : // R4 R8
                              first_level[gf]; // R5 R7
    end
  endgenerate

  // Read view of the second port, bit by bit
  genvar gs;
  generate
    for (gs = 0; gs < SECOND_PINS; gs++) begin : g_second_view
      assign second_view[gs] = second_port_direction_bits[gs] ?
                               second_data_r[gs] : // R4 R8
                               second_level[gs]; // R5 R7
    end
  endgenerate

  // Read word for the selected register; unmapped reads give zero
  always_comb begin
    rd_word = tpd_pkg::tpd_word_t'(`TPD_READ_IDLE);
    case (rd_sel)
      tpd_pkg::TPD_SEL_FIRST_DATA: begin
        rd_word[FIRST_PINS-1:0] = first_view; // R1 R9
      end
      tpd_pkg::TPD_SEL_SECOND_DATA: begin
        rd_word[SECOND_PINS-1:0] = second_view; // R2
      end
      tpd_pkg::TPD_SEL_FIRST_LEVEL: begin
        rd_word[FIRST_PINS-1:0] = first_level;
      end
      tpd_pkg::TPD_SEL_SECOND_LEVEL: begin
        rd_word[SECOND_PINS-1:0] = second_level;
      end
      tpd_pkg::TPD_SEL_FIRST_DRIVE: begin
        rd_word[FIRST_PINS-1:0] = first_oe_r;
      end
      tpd_pkg::TPD_SEL_SECOND_DRIVE: begin
        rd_word[SECOND_PINS-1:0] = second_oe_r;
      end
      tpd_pkg::TPD_SEL_NONE: begin
        rd_word = tpd_pkg::tpd_word_t'(`TPD_READ_IDLE);
      end
      default: begin
        rd_word = tpd_pkg::tpd_word_t'(`TPD_READ_IDLE);
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_data_r <= tpd_pkg::tpd_word_t'(`TPD_READ_IDLE);
    end else if (reg_rd_en) begin
      rd_data_r <= rd_word;
    end else begin
      rd_data_r <= tpd_pkg::tpd_word_t'(`TPD_READ_IDLE);
    end
  end

  assign reg_rd_data = rd_data_r;

endmodule : tpd_port_data

// [src/tpd_defs.svh]
// Constants for the two-port pin data block: offsets, widths, reset values.
// Assumes inclusion by its bare name from the block's design files.
`ifndef TPD_DEFS_SVH
`define TPD_DEFS_SVH

// Register word and pin counts
`define TPD_REG_W         16
`define TPD_FIRST_PINS    10
`define TPD_SECOND_PINS   16
`define TPD_ADDR_W        8

// Register offsets on the plain register port
`define TPD_OFS_FIRST_DATA   8'h00
`define TPD_OFS_SECOND_DATA  8'h04
`define TPD_OFS_FIRST_LEVEL  8'h08
`define TPD_OFS_SECOND_LEVEL 8'h0c
`define TPD_OFS_FIRST_DRIVE  8'h10
`define TPD_OFS_SECOND_DRIVE 8'h14

// Reset values
`define TPD_DATA_RST      16'h0000
`define TPD_READ_IDLE     16'h0000

// Synchroniser depth on pin inputs
`define TPD_SYNC_STAGES   2

`endif

// [src/tpd_pkg.sv]
// Types shared by the two-port pin data block.
// Assumes the constants header is compiled alongside.
package tpd_pkg;

  // Register select, one-hot
  typedef enum logic [6:0] {
    TPD_SEL_NONE         = 7'h01,
    TPD_SEL_FIRST_DATA   = 7'h02,
    TPD_SEL_SECOND_DATA  = 7'h04,
    TPD_SEL_FIRST_LEVEL  = 7'h08,
    TPD_SEL_SECOND_LEVEL = 7'h10,
    TPD_SEL_FIRST_DRIVE  = 7'h20,
    TPD_SEL_SECOND_DRIVE = 7'h40
  } tpd_reg_sel_t;

  typedef logic [15:0] tpd_word_t;

endpackage : tpd_pkg

// [src/tpd_sync2.sv]
// Two flip-flop synchroniser for a vector of pin levels.
// Assumes each bit is an independent level from outside the mclk domain.
`timescale 1ns/100ps
module tpd_sync2 #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
    end
  end

  assign sync_out = sync_r;

endmodule : tpd_sync2

// [test/tpd_pin_board.sv]
// Board model for one port: resolves the level on each pin wire.
// Assumes oe high means the block drives that wire.
`timescale 1ns/100ps
module tpd_pin_board #(
  parameter int W = 16
) (
  // Block side
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  // Board side
  input  wire logic [W-1:0] board_level,
  output logic      [W-1:0] pin_wire
);
  // Undriven pins show the board's own level
  always_comb pin_wire = (pin_oe & pin_out) | (~pin_oe & board_level);
endmodule : tpd_pin_board

// [test/tpd_port_data_sva.sv]
// Port-level checker for the two-port pin data block.
// Assumes binding onto tpd_port_data with its parameters.
`timescale 1ns/100ps
`include "tpd_defs.svh"
module tpd_port_data_sva #(
  parameter int FIRST_PINS  = 10,
  parameter int SECOND_PINS = 16,
  parameter int ADDR_W      = 8
) (
  // Clock, reset, register port
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [ADDR_W-1:0]      reg_addr,
  input wire logic [15:0]            reg_wr_data,
  input wire logic                   reg_wr_en,
  input wire logic                   reg_rd_en,
  input wire logic [15:0]            reg_rd_data,
  // Configuration
  input wire logic [FIRST_PINS-1:0]  first_port_direction_bits,
  input wire logic [FIRST_PINS-1:0]  first_port_general_sel,
  input wire logic [SECOND_PINS-1:0] second_port_direction_bits,
  input wire logic [SECOND_PINS-1:0] second_port_general_sel,
  // Pins
  input wire logic [FIRST_PINS-1:0]  first_port_pin_out,
  input wire logic [FIRST_PINS-1:0]  first_port_pin_oe,
  input wire logic [SECOND_PINS-1:0] second_port_pin_out,
  input wire logic [SECOND_PINS-1:0] second_port_pin_oe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic wf, ws, rf, rs;
  assign wf = reg_wr_en && reg_addr == `TPD_OFS_FIRST_DATA;
  assign ws = reg_wr_en && reg_addr == `TPD_OFS_SECOND_DATA;
  assign rf = reg_rd_en && reg_addr == `TPD_OFS_FIRST_DATA;
  assign rs = reg_rd_en && reg_addr == `TPD_OFS_SECOND_DATA;
  a_reset_clear: assert property (disable iff (1'b0) $past(rst) |->
    first_port_pin_out == '0 && second_port_pin_oe == '0 && reg_rd_data == 16'h0000 &&
    first_port_pin_oe == '0 && second_port_pin_out == '0)
    else $error("outputs not clear after reset");
  a_oe_first: assert property (!$past(rst) |->
    first_port_pin_oe == $past(first_port_direction_bits & first_port_general_sel))
    else $error("first oe wrong");
  a_oe_second: assert property (!$past(rst) |->
    second_port_pin_oe == $past(second_port_direction_bits & second_port_general_sel))
    else $error("second oe wrong");
  a_write_first: assert property (wf |=>
    first_port_pin_out == $past(reg_wr_data[FIRST_PINS-1:0])) else $error("first write lost");
  a_write_second: assert property (ws |=>
    second_port_pin_out == $past(reg_wr_data)) else $error("second write lost");
  a_hold_out: assert property (!wf |=> $stable(first_port_pin_out))
    else $error("first data changed without write");
  a_rd_idle: assert property (!reg_rd_en |=> reg_rd_data == 16'h0000)
    else $error("read data outside its cycle");
  a_rd_reserved: assert property (rf |=> reg_rd_data[15:10] == 6'h00)
    else $error("reserved bits nonzero");
  a_rd_stored_first: assert property (rf |=>
    ((reg_rd_data[9:0] ^ $past(first_port_pin_out)) & $past(first_port_direction_bits)) == '0)
    else $error("first read not stored value");
  a_rd_stored_second: assert property (rs |=>
    ((reg_rd_data ^ $past(second_port_pin_out)) & $past(second_port_direction_bits)) == '0)
    else $error("second read not stored value");
endmodule : tpd_port_data_sva

bind tpd_port_data tpd_port_data_sva #(.FIRST_PINS(FIRST_PINS), .SECOND_PINS(SECOND_PINS),
  .ADDR_W(ADDR_W)) u_sva (.mclk, .rst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
  .reg_rd_data, .first_port_direction_bits, .first_port_general_sel,
  .second_port_direction_bits, .second_port_general_sel, .first_port_pin_out,
  .first_port_pin_oe, .second_port_pin_out, .second_port_pin_oe);

// [test/tpd_port_data_tb.sv]
// Self-checking bench for the two-port pin data block.
// Assumes board models on both ports and the bound checker.
`timescale 1ns/100ps
`include "tpd_defs.svh"
module tpd_port_data_tb;
  logic        mclk, rst, reg_wr_en, reg_rd_en;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic [9:0]  f_dir, f_sel, f_in, f_out, f_oe, f_lvl;
  logic [15:0] s_dir, s_sel, s_in, s_out, s_oe, s_lvl;
  int          n_mismatch, compares, cycles;

  tpd_port_data DUT (.mclk, .rst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
    .reg_rd_data, .first_port_direction_bits(f_dir), .first_port_general_sel(f_sel),
    .second_port_direction_bits(s_dir), .second_port_general_sel(s_sel),
    .first_port_pin_in(f_in), .first_port_pin_out(f_out), .first_port_pin_oe(f_oe),
    .second_port_pin_in(s_in), .second_port_pin_out(s_out), .second_port_pin_oe(s_oe));
  tpd_pin_board #(.W(10)) u_bf (.pin_out(f_out), .pin_oe(f_oe), .board_level(f_lvl),
    .pin_wire(f_in));
  tpd_pin_board #(.W(16)) u_bs (.pin_out(s_out), .pin_oe(s_oe), .board_level(s_lvl),
    .pin_wire(s_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1 chk(what, exp, reg_rd_data);
  endtask : rd

  // New configuration, then time for pin levels to pass the synchroniser
  task automatic cfg(input logic [9:0] fd, fs, fl, input logic [15:0] sd, ss, sl);
    @(posedge mclk);
    f_dir <= fd;
    f_sel <= fs;
    f_lvl <= fl;
    s_dir <= sd;
    s_sel <= ss;
    s_lvl <= sl;
    repeat (5) @(posedge mclk);
    #1;
  endtask : cfg

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      conclude();
    end
  end

  initial begin
    {rst, reg_wr_en, reg_rd_en, reg_addr, reg_wr_data} = '1;
    {reg_wr_en, reg_rd_en, f_dir, f_sel, f_lvl, s_dir, s_sel, s_lvl} = '0;
    {n_mismatch, compares, cycles} = '0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(`TPD_OFS_FIRST_DATA, 16'h0000, "first data");
    rd(`TPD_OFS_SECOND_DATA, 16'h0000, "second data");
    rd(8'h20, 16'h0000, "unmapped");
    $display("test reset done");
    cfg(10'h3ff, 10'h3ff, 10'h000, 16'hffff, 16'hffff, 16'h0000);
    wr(`TPD_OFS_FIRST_DATA, 16'h015a);
    chk("first pins", 16'h015a, {6'h00, f_in});
    chk("first oe", 16'h03ff, {6'h00, f_oe});
    rd(`TPD_OFS_FIRST_DATA, 16'h015a, "first data");
    rd(`TPD_OFS_FIRST_LEVEL, 16'h015a, "first level reg");
    rd(`TPD_OFS_FIRST_DRIVE, 16'h03ff, "first drive reg");
    rd(`TPD_OFS_SECOND_DRIVE, 16'hffff, "second drive reg");
    wr(`TPD_OFS_SECOND_DATA, 16'ha5c3);
    chk("second pins", 16'ha5c3, s_in);
    rd(`TPD_OFS_SECOND_DATA, 16'ha5c3, "second data");
    $display("test general output done");
    cfg(10'h3ff, 10'h000, 10'h2a5, 16'hffff, 16'h0000, 16'h5a3c);
    chk("oe other function", 16'h0000, {6'h00, f_oe} | s_oe);
    rd(`TPD_OFS_FIRST_DATA, 16'h015a, "first data");
    wr(`TPD_OFS_SECOND_DATA, 16'h1234);
    chk("second pins", 16'h5a3c, s_in);
    rd(`TPD_OFS_SECOND_DATA, 16'h1234, "second data");
    rd(`TPD_OFS_SECOND_LEVEL, 16'h5a3c, "second level reg");
    rd(`TPD_OFS_FIRST_DRIVE, 16'h0000, "first drive reg");
    $display("test other output done");
    cfg(10'h000, 10'h3ff, 10'h2a5, 16'h0000, 16'hffff, 16'h5a3c);
    rd(`TPD_OFS_FIRST_DATA, 16'h02a5, "first level");
    rd(`TPD_OFS_SECOND_DATA, 16'h5a3c, "second level");
    wr(`TPD_OFS_FIRST_DATA, 16'h0033);
    chk("first pins", 16'h02a5, {6'h00, f_in});
    rd(`TPD_OFS_FIRST_DATA, 16'h02a5, "first level");
    cfg(10'h000, 10'h000, 10'h15a, 16'h0000, 16'h0000, 16'hc3a5);
    rd(`TPD_OFS_SECOND_DATA, 16'hc3a5, "second level");
    cfg(10'h3ff, 10'h000, 10'h15a, 16'hffff, 16'h0000, 16'hc3a5);
    rd(`TPD_OFS_FIRST_DATA, 16'h0033, "first data");
    rd(`TPD_OFS_SECOND_DATA, 16'h1234, "second data");
    $display("test input done");
    // Mid-run reset with both ports reading their stored bits
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(`TPD_OFS_FIRST_DATA, 16'h0000, "first data");
    rd(`TPD_OFS_SECOND_DATA, 16'h0000, "second data");
    $display("test mid-run reset done");
    conclude();
  end
endmodule : tpd_port_data_tb
